// *** verilog/spsc_core.sv ***
// Serial special pointer commands, interrupt log writer, descriptor flags
`timescale 1ns/1ps
module spsc_core #(
  parameter int MEM_AW = 15,
  parameter logic [7:0] POLL_OP = 8'hD6
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [1:0] pointer_select_field,
  input wire logic [15:0] rt1_ctrl_addr,
  input wire logic [15:0] rt2_ctrl_addr,
  input wire logic [15:0] rt1_table_base,
  input wire logic [15:0] rt2_table_base,
  input wire logic cmd_done,
  input wire logic [15:0] cmd_ctrl_addr,
  input wire logic irq_valid,
  input wire logic [15:0] irq_info_word,
  input wire logic [15:0] irq_addr_word,
  input wire logic log_addr_read,
  output logic [15:0] active_pointer,
  output logic [15:0] log_address,
  output logic irq_busy,
  output logic wr_overrun
);
  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [2:0] sck;
    logic [1:0] cs;
    logic [1:0] mo;
    spsc_pkg::spsc_state_t st;
    spsc_pkg::spsc_mode_t mode;
    logic [1:0] step;
    logic [4:0] cnt;
    logic [7:0] op;
    logic [3:0][15:0] ptr;
    logic [15:0] act;
    logic [15:0] tx;
    logic [15:0] rx;
    logic miso;
    logic miso_oe;
    logic [15:0] log;
    logic [1:0] irq_ph;
    logic irq_busy;
    logic [15:0] irq_info;
    logic [15:0] irq_aw;
    logic pend_clr;
    logic [15:0] clr_addr;
    logic pend_set;
    logic [15:0] set_addr;
    logic ovr;
  } spsc_core_state_t;

  spsc_core_state_t q;
  spsc_core_state_t d;
  logic [15:0] ram [0:(1<<MEM_AW)-1];
  logic [15:0] p;
  logic [15:0] rd;
  logic [15:0] rmw;
  logic rise;
  logic fall;
  logic fetch;
  logic go_rd;
  logic push;
  logic drain;
  logic we;
  logic [15:0] wa;
  logic [15:0] wd;
  logic f_in_ready;
  logic f_out_valid;
  logic [31:0] f_out_data;
  logic [31:0] push_data;

  // ****************************************************
  // Helpers
  // ****************************************************
  // True when the address is a control word of either descriptor table
  function automatic logic ctrl_hit(input logic [15:0] a,
                                    input logic [15:0] b1,
                                    input logic [15:0] b2);
    logic [15:0] o1;
    logic [15:0] o2;
    o1 = a - b1;
    o2 = a - b2;
    return ((o1 < spsc_pkg::CTRL_SPAN) && (o1[1:0] == 2'h0)) ||
           ((o2 < spsc_pkg::CTRL_SPAN) && (o2[1:0] == 2'h0));
  endfunction

  // Step one word back inside the log buffer
  function automatic logic [8:0] log_dec(input logic [8:0] a);
    return (a == spsc_pkg::LOG_FIRST) ? spsc_pkg::LOG_LAST : a - 9'h001;
  endfunction

  // Next even log slot, circular
  function automatic logic [8:0] log_next(input logic [8:0] a);
    return (a == spsc_pkg::LOG_LAST_EVEN) ? spsc_pkg::LOG_FIRST :
           a + 9'h002;
  endfunction

  // Offset added by the indirect commands, from op code bits 4:3
  function automatic logic [15:0] ind_off(input logic [7:0] op);
    return {14'h0000, op[4:3]} - 16'h0001;
  endfunction

  function automatic logic is_ind(input logic [7:0] op);
    return (op == spsc_pkg::OP_IND_RD0) || (op == spsc_pkg::OP_IND_RD1) ||
           (op == spsc_pkg::OP_IND_RD2) || (op == spsc_pkg::OP_IND_WR0) ||
           (op == spsc_pkg::OP_IND_WR1) || (op == spsc_pkg::OP_IND_WR2);
  endfunction

  // ****************************************************
  // Write buffer between host words and the RAM port
  // ****************************************************
  spsc_fifo2 #(
    .W(32),
    .DEPTH(2)
  ) u_wbuf (
    .clock(clock),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(push_data),
    .out_valid(f_out_valid),
    .out_ready(drain),
    .out_data(f_out_data)
  );

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    d = q;
    p = q.ptr[pointer_select_field];
    rd = 16'h0000;
    rmw = 16'h0000;
    fetch = 1'b0;
    go_rd = 1'b0;
    push = 1'b0;
    drain = 1'b0;
    we = 1'b0;
    wa = 16'h0000;
    wd = 16'h0000;
    push_data = 32'h0000_0000;
    // Pin synchronisers; stage 0 only feeds stage 1
    d.sck = {q.sck[1:0], spi_sck};
    d.cs = {q.cs[0], spi_cs_n};
    d.mo = {q.mo[0], spi_mosi};
    rise = q.sck[1] & ~q.sck[2];
    fall = ~q.sck[1] & q.sck[2];

    // Reading the log address clears the interrupt count
    if (log_addr_read) begin
      d.log[15:9] = 7'h00;
    end

    // RAM write port: log words, then flag clear, then flag set, then host
    if (q.irq_ph[0]) begin
      we = 1'b1;
      wa = {7'h00, q.log[8:0]};
      wd = q.irq_info;
      d.irq_ph = 2'b10;
    end else if (q.irq_ph[1]) begin
      we = 1'b1;
      wa = {7'h00, q.log[8:0] + 9'h001};
      wd = q.irq_aw;
      d.log[8:0] = log_next(q.log[8:0]);
      if (d.log[15:9] != spsc_pkg::LOG_CNT_MAX) begin
        d.log[15:9] = d.log[15:9] + 7'h01;
      end
      d.irq_ph = 2'b00;
    end else if (q.pend_clr) begin
      rmw = ram[q.clr_addr[MEM_AW-1:0]];
      we = 1'b1;
      wa = q.clr_addr;
      wd = rmw;
      wd[spsc_pkg::FLAG_BIT] = 1'b0;
      d.pend_clr = 1'b0;
    end else if (q.pend_set) begin
      rmw = ram[q.set_addr[MEM_AW-1:0]];
      we = 1'b1;
      wa = q.set_addr;
      wd = rmw;
      wd[spsc_pkg::FLAG_BIT] = 1'b1;
      d.pend_set = 1'b0;
    end else begin
      drain = f_out_valid;
      we = f_out_valid;
      wa = f_out_data[31:16];
      wd = f_out_data[15:0];
    end

    // Host serial side; deselect ends any command
    if (q.cs[1]) begin
      d.st = spsc_pkg::ST_OPCODE;
      d.mode = spsc_pkg::MD_NONE;
      d.cnt = 5'h00;
      d.miso = 1'b0;
      d.miso_oe = 1'b0;
    end else begin
      case (q.st)
        spsc_pkg::ST_OPCODE: begin
          if (rise && (q.mode == spsc_pkg::MD_NONE)) begin
            d.op = {q.op[6:0], q.mo[1]};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == spsc_pkg::OP_BITS - 5'h01) begin
              d.st = spsc_pkg::ST_EXEC;
              d.step = 2'h0;
              d.cnt = 5'h00;
            end
          end
        end
        spsc_pkg::ST_EXEC: begin
          d.step = q.step + 2'h1;
          if (q.op == spsc_pkg::OP_CW_RT1) begin
            p = rt1_ctrl_addr;
            d.mode = spsc_pkg::MD_INC;
            go_rd = 1'b1;
          end else if (q.op == spsc_pkg::OP_CW_RT2) begin
            p = rt2_ctrl_addr;
            d.mode = spsc_pkg::MD_INC;
            go_rd = 1'b1;
          end else if (q.op == spsc_pkg::OP_LOG_RD) begin
            p = {7'h00, log_dec(q.log[8:0])};
            d.mode = spsc_pkg::MD_DEC;
            go_rd = 1'b1;
          end else if (q.op == POLL_OP) begin
            d.mode = spsc_pkg::MD_POLL;
            go_rd = 1'b1;
          end else if (is_ind(q.op)) begin
            if (q.step == 2'h0) begin
              p = p + ind_off(q.op);
            end else if (q.step == 2'h1) begin
              p = ram[p[MEM_AW-1:0]];
            end else if (q.op[7]) begin
              d.mode = spsc_pkg::MD_INC;
              d.st = spsc_pkg::ST_WRITE;
            end else begin
              d.mode = spsc_pkg::MD_INC;
              go_rd = 1'b1;
            end
          end else begin
            // Other op codes belong elsewhere: stay quiet until deselect
            d.mode = spsc_pkg::MD_INC;
            d.st = spsc_pkg::ST_OPCODE;
          end
        end
        spsc_pkg::ST_READ: begin
          if (fall && (q.cnt != 5'h00)) begin
            d.tx = {q.tx[14:0], 1'b0};
            d.miso = q.tx[14];
          end
          if (rise) begin
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == spsc_pkg::WORD_BITS - 5'h01) begin
              d.cnt = 5'h00;
              fetch = 1'b1;
            end
          end
        end
        spsc_pkg::ST_WRITE: begin
          if (rise) begin
            d.rx = {q.rx[14:0], q.mo[1]};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == spsc_pkg::WORD_BITS - 5'h01) begin
              d.cnt = 5'h00;
              push_data = {p, q.rx[14:0], q.mo[1]};
              push = 1'b1;
              d.ovr = q.ovr | ~f_in_ready;
              p = p + 16'h0001;
            end
          end
        end
        default: begin
          d.st = spsc_pkg::ST_OPCODE;
        end
      endcase
    end

    // Word fetch: load shifter, clear flag, then move the pointer
    if (go_rd) begin
      d.st = spsc_pkg::ST_READ;
      fetch = 1'b1;
    end
    if (fetch) begin
      rd = ram[p[MEM_AW-1:0]];
      d.tx = rd;
      d.miso = rd[15];
      d.miso_oe = 1'b1;
      if (ctrl_hit(p, rt1_table_base, rt2_table_base)) begin
        d.pend_clr = 1'b1;
        d.clr_addr = p;
      end
      if (d.mode == spsc_pkg::MD_DEC) begin
        p = {7'h00, log_dec(p[8:0])};
      end else if (d.mode == spsc_pkg::MD_POLL) begin
        p = p + spsc_pkg::POLL_STEP;
      end else if (!ctrl_hit(p + 16'h0001, rt1_table_base,
                             rt2_table_base)) begin
        p = p + 16'h0001;
      end
    end

    // Outside events; a new set wins over one just served
    if (irq_valid && (q.irq_ph == 2'b00)) begin
      d.irq_ph = 2'b01;
      d.irq_info = irq_info_word;
      d.irq_aw = irq_addr_word;
    end
    if (cmd_done) begin
      d.pend_set = 1'b1;
      d.set_addr = cmd_ctrl_addr;
    end

    // Active pointer write-back and registered mirrors
    d.ptr[pointer_select_field] = p;
    d.act = p;
    d.irq_busy = (d.irq_ph != 2'b00);
  end

  // ****************************************************
  // Registers and RAM
  // ****************************************************
  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= spsc_pkg::ST_OPCODE;
      q.mode <= spsc_pkg::MD_NONE;
      q.cs <= 2'h3;
      q.ptr <= {4{spsc_pkg::PTR_RST}};
      q.act <= spsc_pkg::PTR_RST;
      q.log <= spsc_pkg::LOG_RST;
    end else begin
      q <= d;
    end
  end

  // Single write port RAM
  always_ff @(posedge clock) begin
    if (we) begin
      ram[wa[MEM_AW-1:0]] <= wd;
    end
  end

  assign spi_miso = q.miso;
  assign spi_miso_oe = q.miso_oe;
  assign active_pointer = q.act;
  assign log_address = q.log;
  assign irq_busy = q.irq_busy;
  assign wr_overrun = q.ovr;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_cw_rt1;
    @(posedge clock) disable iff (!arst_n)
    (q.st == spsc_pkg::ST_EXEC && q.op == spsc_pkg::OP_CW_RT1 && !q.cs[1])
    |=> (q.act == $past(rt1_ctrl_addr) +
         ($past(ctrl_hit(rt1_ctrl_addr + 16'h0001, rt1_table_base,
                         rt2_table_base)) ? 16'h0000 : 16'h0001));
  endproperty
  a_cw_rt1: assert property (p_cw_rt1)
    else $error("control word copy from first terminal wrong");

  property p_cw_rt2;
    @(posedge clock) disable iff (!arst_n)
    (q.st == spsc_pkg::ST_EXEC && q.op == spsc_pkg::OP_CW_RT2 && !q.cs[1])
    |=> (q.act == $past(rt2_ctrl_addr) +
         ($past(ctrl_hit(rt2_ctrl_addr + 16'h0001, rt1_table_base,
                         rt2_table_base)) ? 16'h0000 : 16'h0001));
  endproperty
  a_cw_rt2: assert property (p_cw_rt2)
    else $error("control word copy from second terminal wrong");

  property p_ind_add;
    @(posedge clock) disable iff (!arst_n)
    (q.st == spsc_pkg::ST_EXEC && q.step == 2'h0 && !q.cs[1] &&
     (q.op == spsc_pkg::OP_IND_RD2 || q.op == spsc_pkg::OP_IND_WR2))
    |=> (q.act == $past(q.act) + 16'h0002);
  endproperty
  a_ind_add: assert property (p_ind_add)
    else $error("indirect offset not added");

  property p_poll_step;
    @(posedge clock) disable iff (!arst_n)
    (fetch && d.mode == spsc_pkg::MD_POLL)
    |=> (q.act == $past(q.act) + 16'h0004);
  endproperty
  a_poll_step: assert property (p_poll_step)
    else $error("poll did not step by four");

  property p_log_range;
    @(posedge clock) disable iff (!arst_n)
    (q.log[0] == 1'b0) && (q.log[8:0] >= spsc_pkg::LOG_FIRST) &&
    (q.log[8:0] <= spsc_pkg::LOG_LAST_EVEN);
  endproperty
  a_log_range: assert property (p_log_range)
    else $error("log address out of range or odd");

  property p_log_load;
    @(posedge clock) disable iff (!arst_n)
    (q.st == spsc_pkg::ST_EXEC && q.op == spsc_pkg::OP_LOG_RD && !q.cs[1])
    |=> (q.act == {7'h00, log_dec(log_dec($past(q.log[8:0])))});
  endproperty
  a_log_load: assert property (p_log_load)
    else $error("log read pointer load wrong");

  property p_log_wrap;
    @(posedge clock) disable iff (!arst_n)
    (fetch && d.mode == spsc_pkg::MD_DEC) |=>
    (q.act[15:9] == 7'h00 && q.act[8:0] >= spsc_pkg::LOG_FIRST);
  endproperty
  a_log_wrap: assert property (p_log_wrap)
    else $error("log read left the buffer");

  property p_irq_log;
    @(posedge clock) disable iff (!arst_n)
    (irq_valid && q.irq_ph == 2'b00 && !log_addr_read) |=> q.irq_busy ##2
    (q.log[8:0] == log_next($past(q.log[8:0], 3)) && !q.irq_busy);
  endproperty
  a_irq_log: assert property (p_irq_log)
    else $error("log address not advanced after interrupt");

  property p_wr_inc;
    @(posedge clock) disable iff (!arst_n)
    push |=> (q.act == $past(q.act) + 16'h0001);
  endproperty
  a_wr_inc: assert property (p_wr_inc)
    else $error("pointer not advanced after write word");
endmodule

// *** include/spsc_pkg.sv ***
// Constants and types for the serial special pointer command block
// How it works
// - Op 0x48 copies first terminal control-word address into pointer, reads it.
// - Op 0x50 copies second terminal control-word address into pointer, reads it.
// - After those control-word reads the pointer steps up by one, unless the next word is a control word.
// - Ops 0x68/0x70/0x78 add 0/1/2, load pointer from memory, then read.
// - Ops 0xE8/0xF0/0xF8 add 0/1/2, load pointer from memory, then write.
// - Indirect commands allow one word or auto-incrementing multi-word transfers.
// - Completion of a bus command sets its control word accessed flag.
// - Host read of a control word clears its accessed flag.
// - Poll command reads the pointed word, then adds four to pointer.
// - Poll: 8 op clocks, 16 per word; further words come four apart.
// - Each interrupt writes two log words and advances the log address.
// - Log occupies 0x180-0x1BF; log address stays even, 0x180-0x1BE.
// - Op 0x58 loads pointer with log address minus one, wrapping to 0x1BF.
// - Log read returns newest address word, then decrements toward its info.
// - Log address bits 15:9 count interrupts and never reach the pointer.
// - Only the log read decrements the pointer, after every word.
// - Log read decrements wrap from 0x180 back to 0x1BF.
// - Each finished two-byte word moves the pointer, except an auto-increment read held before a control word; host extends with clocks.
// - Four pointers exist; a two-bit select field picks the active one.
// - Auto-increment reads never prefetch into a descriptor control word, so its flag survives; poll and log read steps skip the check.
package spsc_pkg;
  // ****************************************************
  // Op codes
  // ****************************************************
  localparam logic [7:0] OP_CW_RT1 = 8'h48;
  localparam logic [7:0] OP_CW_RT2 = 8'h50;
  localparam logic [7:0] OP_LOG_RD = 8'h58;
  localparam logic [7:0] OP_IND_RD0 = 8'h68;
  localparam logic [7:0] OP_IND_RD1 = 8'h70;
  localparam logic [7:0] OP_IND_RD2 = 8'h78;
  localparam logic [7:0] OP_IND_WR0 = 8'hE8;
  localparam logic [7:0] OP_IND_WR1 = 8'hF0;
  localparam logic [7:0] OP_IND_WR2 = 8'hF8;
  // ****************************************************
  // Log buffer, table and counting constants
  // ****************************************************
  localparam logic [8:0] LOG_FIRST = 9'h180;
  localparam logic [8:0] LOG_LAST = 9'h1BF;
  localparam logic [8:0] LOG_LAST_EVEN = 9'h1BE;
  localparam logic [6:0] LOG_CNT_MAX = 7'h7F;
  localparam logic [15:0] POLL_STEP = 16'h0004;
  localparam logic [15:0] CTRL_SPAN = 16'h0200;
  localparam int unsigned FLAG_BIT = 15;
  localparam logic [4:0] OP_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] LOG_RST = 16'h0180;
  // ****************************************************
  // State and transfer mode types
  // ****************************************************
  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_READ = 4'b0100,
    ST_WRITE = 4'b1000
  } spsc_state_t;
  typedef enum logic [3:0] {
    MD_NONE = 4'b0001,
    MD_INC = 4'b0010,
    MD_DEC = 4'b0100,
    MD_POLL = 4'b1000
  } spsc_mode_t;
endpackage

// *** verilog/spsc_fifo2.sv ***
// Small valid/ready buffer for host write words
`timescale 1ns/1ps
module spsc_fifo2 #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } spsc_fifo_state_t;

  spsc_fifo_state_t q;
  spsc_fifo_state_t d;
  logic put;
  logic take;

  // Handshake flags straight from the count
  assign in_ready = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];

  // Pointer and count update
  always_comb begin
    d = q;
    put = in_valid & in_ready;
    take = out_valid & out_ready;
    if (put) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == LAST) ? '0 : q.wp + AW'(1);
    end
    if (take) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + AW'(1);
    end
    if (put && !take) begin
      d.cnt = q.cnt + CW'(1);
    end else if (take && !put) begin
      d.cnt = q.cnt - CW'(1);
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// *** verification/spsc_host.sv ***
// Host serial master model that frames op codes and data words
`timescale 1ns/1ps
module spsc_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic [71:0] tx;
  logic in_bit;
  // Idle link: clock parked low, device deselected
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    in_bit = 1'b0;
  end
  // One frame: op code then n words each way, MSB first, 80 ns period
  task automatic frame(input logic [7:0] op, input int n,
                       input logic [63:0] wd, output logic [63:0] rd);
    rd = '0;
    tx = {op, wd};
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 + 16 * n; i++) begin
      spi_mosi = tx[71];
      tx = {tx[70:0], 1'b0};
      #40 spi_sck = 1'b1;
      // An undriven line is seen as the inverse of its last level
      in_bit = spi_miso_oe ? spi_miso : ~in_bit;
      if (i >= 8) rd = {rd[62:0], in_bit};
      #40 spi_sck = 1'b0;
    end
    #40 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #80;
  endtask
endmodule

// *** verification/tb_spsc_core.sv ***
// Self-checking bench for the serial special pointer command block
`timescale 1ns/1ps
`define CHECK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); \
  end \
end
module tb_spsc_core;
  logic clock, arst_n, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic cmd_done, irq_valid, log_addr_read, irq_busy, wr_overrun;
  logic [1:0] pointer_select_field;
  logic [15:0] rt1_ctrl_addr, rt2_ctrl_addr, cmd_ctrl_addr, irq_info_word;
  logic [15:0] irq_addr_word, active_pointer, log_address;
  logic [63:0] rd;
  int num_errors, checks_done;
  spsc_core i_spsc_core (.clock(clock), .arst_n(arst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .pointer_select_field(pointer_select_field),
    .rt1_ctrl_addr(rt1_ctrl_addr), .rt2_ctrl_addr(rt2_ctrl_addr),
    .rt1_table_base(16'h4000), .rt2_table_base(16'h5000),
    .cmd_done(cmd_done), .cmd_ctrl_addr(cmd_ctrl_addr), .irq_valid(irq_valid),
    .irq_info_word(irq_info_word), .irq_addr_word(irq_addr_word),
    .log_addr_read(log_addr_read), .active_pointer(active_pointer),
    .log_address(log_address), .irq_busy(irq_busy), .wr_overrun(wr_overrun));
  spsc_host i_spsc_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  // 200 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ********
  // Helpers
  // ********
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input logic [63:0] wd);
    step(1);
    i_spsc_host.frame(op, n, wd, rd);
    step(2);
  endtask
  // Op-only frame through the first terminal leaves the pointer at a+1, or at a when a+1 is a control word
  task automatic park(input logic [15:0] a);
    rt1_ctrl_addr = a;
    cmd(8'h48, 0, '0);
  endtask
  // Valid held a second cycle, which must be ignored while busy
  task automatic irq(input logic [15:0] info, input logic [15:0] addr);
    int k;
    irq_info_word = info;
    irq_addr_word = addr;
    irq_valid = 1'b1;
    step(2);
    irq_valid = 1'b0;
    for (k = 0; k < 16 && irq_busy !== 1'b0; k++) step(1);
    if (k == 16) begin
      num_errors++;
      $display("unexpected %0t: log write hang", $time);
      end_sim();
    end
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_log();
    irq(16'h0A5A, 16'h0210);
    irq(16'h0214, 16'h4000);
    `CHECK(log_address, 16'h0584)
  endtask
  task automatic t_cw();
    rt1_ctrl_addr = 16'h0180;
    cmd(8'h48, 2, '0);
    `CHECK(rd[31:0], 32'h0A5A_0210)
    rt2_ctrl_addr = 16'h0182;
    cmd(8'h50, 1, '0);
    `CHECK(rd[15:0], 16'h0214)
  endtask
  task automatic t_ind();
    logic [15:0] tgt [3] = '{16'h0210, 16'h0214, 16'h4000};
    for (int k = 0; k < 3; k++) begin
      park(16'h0180);
      cmd(8'hE8 + 8'(8 * k), 1, {16'(k + 1) * 16'h1111, 48'h0000_0000_0000});
      `CHECK(active_pointer, tgt[k] + 16'h0001)
    end
    for (int k = 0; k < 3; k++) begin
      park(16'h0180);
      cmd(8'h68 + 8'(8 * k), 1, '0);
      `CHECK(rd[15:0], 16'(k + 1) * 16'h1111)
    end
  endtask
  task automatic t_poll();
    park(16'h020F);
    cmd(8'hD6, 2, '0);
    `CHECK(rd[31:0], 32'h1111_2222)
    `CHECK(active_pointer, 16'h021C)
  endtask
  task automatic t_flag();
    park(16'h3FFF);
    `CHECK(active_pointer, 16'h3FFF)
    cmd_ctrl_addr = 16'h4000;
    cmd_done = 1'b1;
    step(1);
    cmd_done = 1'b0;
    step(8);
    for (int k = 0; k < 2; k++) begin
      rt1_ctrl_addr = 16'h4000;
      cmd(8'h48, 1, '0);
      `CHECK(rd[15:0], k ? 16'h3333 : 16'hB333)
    end
  endtask
  task automatic t_logrd();
    cmd(8'h58, 4, '0);
    `CHECK(rd, 64'h4000_0214_0210_0A5A)
    `CHECK(active_pointer, 16'h01BE)
    log_addr_read = 1'b1;
    step(1);
    log_addr_read = 1'b0;
    step(1);
    `CHECK(log_address, 16'h0184)
  endtask
  task automatic t_wrap();
    for (int k = 0; k < 30; k++) irq(16'h0000, 16'h0000);
    `CHECK(log_address, 16'h3D80)
    cmd(8'h58, 0, '0);
    `CHECK(active_pointer, 16'h01BE)
  endtask
  task automatic t_sel();
    pointer_select_field = 2'b10;
    step(2);
    `CHECK(active_pointer, 16'h0000)
    cmd(8'h00, 1, '0);
    `CHECK(active_pointer, 16'h0000)
    pointer_select_field = 2'b00;
    step(2);
    `CHECK(active_pointer, 16'h01BE)
    `CHECK(wr_overrun, 1'b0)
  endtask
  // Reset, then the scenarios in order; RAM contents carry across them
  initial begin
    arst_n = 1'b0;
    cmd_done = 1'b0;
    irq_valid = 1'b0;
    log_addr_read = 1'b0;
    pointer_select_field = 2'b00;
    rt1_ctrl_addr = 16'h0000;
    rt2_ctrl_addr = 16'h0000;
    cmd_ctrl_addr = 16'h0000;
    irq_info_word = 16'h0000;
    irq_addr_word = 16'h0000;
    step(20);
    arst_n = 1'b1;
    step(3);
    `CHECK(active_pointer, 16'h0000)
    `CHECK(log_address, 16'h0180)
    t_log();
    t_cw();
    t_ind();
    t_poll();
    t_flag();
    t_logrd();
    t_wrap();
    t_sel();
    end_sim();
  end
endmodule
